// ===== rtl/atsd_pkg.sv
// Purpose: Constants and types for the analog test / short detect register bank
// Assumes: 16-bit registers on a plain strobe port, one clock, synchronous reset
// Notes: Offsets are byte addresses of the host control port
// Functional notes
// [R1] Mono copy bit 12 sends left output-converter sample to both channels.
// [R2] Bit 11 high then low retriggers the oscillator inverter-count tuning.
// [R3] Bit 14 moves lineout supply to analog rail; resets to I/O rail.
// [R4] Bit 9 inverts output-converter sampling clock edge; cleared at reset.
// [R5] Bit 8 inverts output-converter data crossing clock edge.
// [R6] Bit 3 inverts input-converter sampling clock edge.
// [R7] Bit 2 inverts input-converter data crossing clock edge.
// [R8] Bit 7 lengthens the output-converter return-to-zero interval.
// [R9] Bit 5 disables return-to-zero; normally leave cleared.
// [R10] Bit 6 doubles amplifier current, only effective in class-A.
// [R11] Bit 4 disables class-AB amplifier operation; normally keep cleared.
// [R12] Bit 1 lowers input-converter bias currents by one fifth.
// [R13] Bit 0 of test register two disables input-converter dither.
// [R14] Bit 10 ties main mid-rail reference to lineout reference.
// [R15] Bit 0 of the preceding debug register enables analog test paths.
// [R16] Bit 13 is a read-write spare driven straight to analog.
// [R17] Right trip level bits 14:12, 25 mA steps, code 3 is 25 mA.
// [R18] Left trip level bits 10:8, same encoding as right channel.
// [R19] Software keeps margin on trip levels; process spread about thirty percent.
// [R20] Center trip level bits 6:4, 50 mA steps, code 3 is 50 mA.
// [R21] Reserved bits read zero and ignore writes.
package atsd_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] TEST_ONE_OFFS = 16'h0038;
  localparam logic [ADDR_W-1:0] TEST_TWO_OFFS = 16'h003a;
  localparam logic [ADDR_W-1:0] SHORT_CTRL_OFFS = 16'h003c;
  localparam logic [DATA_W-1:0] TEST_ONE_RST = 16'h0000;
  localparam logic [DATA_W-1:0] TEST_TWO_RST = 16'h0000;
  localparam logic [DATA_W-1:0] SHORT_CTRL_RST = 16'h0000;
  // Writable bit masks; everything else reads zero
  localparam logic [DATA_W-1:0] TEST_ONE_MASK = 16'h0001;
  localparam logic [DATA_W-1:0] TEST_TWO_MASK = 16'h7fff;
  localparam logic [DATA_W-1:0] SHORT_CTRL_MASK = 16'h7777;
  localparam int unsigned TESTMODE_BIT = 0;
  localparam int unsigned LINEOUT_SUPPLY_BIT = 14;
  localparam int unsigned SPARE_BIT = 13;
  localparam int unsigned MONO_BIT = 12;
  localparam int unsigned RETUNE_BIT = 11;
  localparam int unsigned REF_TIE_BIT = 10;
  localparam int unsigned OUT_SAMPLE_INV_BIT = 9;
  localparam int unsigned OUT_DATA_INV_BIT = 8;
  localparam int unsigned RTZ_EXTEND_BIT = 7;
  localparam int unsigned DOUBLE_I_BIT = 6;
  localparam int unsigned RTZ_DIS_BIT = 5;
  localparam int unsigned CLASS_A_BIT = 4;
  localparam int unsigned IN_SAMPLE_INV_BIT = 3;
  localparam int unsigned IN_DATA_INV_BIT = 2;
  localparam int unsigned BIAS_REDUCE_BIT = 1;
  localparam int unsigned DITHER_DIS_BIT = 0;
  localparam int unsigned RIGHT_LVL_LSB = 12;
  localparam int unsigned LEFT_LVL_LSB = 8;
  localparam int unsigned CENTER_LVL_LSB = 4;
  localparam int unsigned LVL_W = 3;

  // Controls driven to the analog section
  typedef struct packed {
    logic test_paths_en;
    logic lineout_supply_select;
    logic spare;
    logic lineout_reference_tie;
    logic out_conv_sample_edge_invert;
    logic out_conv_data_edge_invert;
    logic out_conv_rtz_extend;
    logic out_conv_double_current;
    logic out_conv_rtz_disable;
    logic out_conv_class_a_force;
    logic in_conv_sample_edge_invert;
    logic in_conv_data_edge_invert;
    logic in_conv_bias_reduce;
    logic in_conv_dither_disable;
    logic [LVL_W-1:0] right_short_trip_level;
    logic [LVL_W-1:0] left_short_trip_level;
    logic [LVL_W-1:0] center_short_trip_level;
  } atsd_ana_ctrl_t;

  // Stereo sample pair
  typedef struct packed {
    logic [DATA_W-1:0] left;
    logic [DATA_W-1:0] right;
  } atsd_sample_t;
endpackage : atsd_pkg

// ===== rtl/atsd_regs.sv
// Purpose: Analog test and headphone short detect configuration registers
// Assumes: Host port strobes are one cycle and never both at once
// Notes: Read data is valid only in the cycle after the read strobe
//
// Strobed register access was left to the implementer.
module atsd_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [atsd_pkg::ADDR_W-1:0] addr_i,
  input wire logic [atsd_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [atsd_pkg::DATA_W-1:0] rdata_o,
  // Sample path toward the output converter
  input wire atsd_pkg::atsd_sample_t sample_i,
  input wire logic sample_vld_i,
  output atsd_pkg::atsd_sample_t sample_o,
  output logic sample_vld_o,
  // Analog controls
  output atsd_pkg::atsd_ana_ctrl_t ana_ctrl_o,
  output logic osc_retune_pulse_o
);
  import atsd_pkg::*;

  logic [DATA_W-1:0] test_one_r;
  logic [DATA_W-1:0] test_two_r;
  logic [DATA_W-1:0] short_ctrl_r;
  logic [DATA_W-1:0] rdata_r;
  logic retune_d_r;
  logic retune_pulse_r;
  atsd_ana_ctrl_t ana_r;
  atsd_sample_t sample_r;
  logic sample_vld_r;

  // Address decode
  wire sel_one = addr_i == TEST_ONE_OFFS;
  wire sel_two = addr_i == TEST_TWO_OFFS;
  wire sel_short = addr_i == SHORT_CTRL_OFFS;
  wire wr_one = wr_i && sel_one;
  wire wr_two = wr_i && sel_two;
  wire wr_short = wr_i && sel_short;

  // Masking keeps reserved bits at zero no matter what is written
  wire [DATA_W-1:0] test_one_nxt = wr_one ? (wdata_i & TEST_ONE_MASK) : test_one_r; // R21
  wire [DATA_W-1:0] test_two_nxt = wr_two ? (wdata_i & TEST_TWO_MASK) : test_two_r; // R21
  wire [DATA_W-1:0] short_ctrl_nxt = wr_short ? (wdata_i & SHORT_CTRL_MASK) : short_ctrl_r; // R21

  // Read mux; unmapped addresses read zero
  wire [DATA_W-1:0] rd_sel = sel_one ? test_one_r :
                             sel_two ? test_two_r :
                             sel_short ? short_ctrl_r : '0;
  wire [DATA_W-1:0] rdata_nxt = rd_i ? rd_sel : '0;

  // Retune fires on the falling edge of the bit: high then low
  wire retune_bit = test_two_r[RETUNE_BIT];
  wire retune_nxt = retune_d_r && !retune_bit; // R2

  // Mono copy: right takes the left sample
  wire mono = test_two_r[MONO_BIT];
  atsd_sample_t sample_nxt;
  assign sample_nxt.left = sample_i.left;
  assign sample_nxt.right = mono ? sample_i.left : sample_i.right; // R1

  // Controls mapped field by field from the stored registers
  atsd_ana_ctrl_t ana_nxt;
  assign ana_nxt.test_paths_en = test_one_r[TESTMODE_BIT]; // R15
  assign ana_nxt.lineout_supply_select = test_two_r[LINEOUT_SUPPLY_BIT]; // R3
  assign ana_nxt.spare = test_two_r[SPARE_BIT]; // R16
  assign ana_nxt.lineout_reference_tie = test_two_r[REF_TIE_BIT]; // R14
  assign ana_nxt.out_conv_sample_edge_invert = test_two_r[OUT_SAMPLE_INV_BIT]; // R4
  assign ana_nxt.out_conv_data_edge_invert = test_two_r[OUT_DATA_INV_BIT]; // R5
  assign ana_nxt.out_conv_rtz_extend = test_two_r[RTZ_EXTEND_BIT]; // R8
  // Doubling only matters while class-AB is off
  assign ana_nxt.out_conv_double_current = test_two_r[DOUBLE_I_BIT] && test_two_r[CLASS_A_BIT]; // R10
  assign ana_nxt.out_conv_rtz_disable = test_two_r[RTZ_DIS_BIT]; // R9
  assign ana_nxt.out_conv_class_a_force = test_two_r[CLASS_A_BIT]; // R11
  assign ana_nxt.in_conv_sample_edge_invert = test_two_r[IN_SAMPLE_INV_BIT]; // R6
  assign ana_nxt.in_conv_data_edge_invert = test_two_r[IN_DATA_INV_BIT]; // R7
  assign ana_nxt.in_conv_bias_reduce = test_two_r[BIAS_REDUCE_BIT]; // R12
  assign ana_nxt.in_conv_dither_disable = test_two_r[DITHER_DIS_BIT]; // R13
  assign ana_nxt.right_short_trip_level = short_ctrl_r[RIGHT_LVL_LSB +: LVL_W]; // R17
  assign ana_nxt.left_short_trip_level = short_ctrl_r[LEFT_LVL_LSB +: LVL_W]; // R18
  assign ana_nxt.center_short_trip_level = short_ctrl_r[CENTER_LVL_LSB +: LVL_W]; // R20

  // Register storage
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      test_one_r <= TEST_ONE_RST;
      test_two_r <= TEST_TWO_RST;
      short_ctrl_r <= SHORT_CTRL_RST;
      rdata_r <= '0;
    end else begin
      test_one_r <= test_one_nxt;
      test_two_r <= test_two_nxt;
      short_ctrl_r <= short_ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Output flops; controls lag the register by one cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      retune_d_r <= 1'b0;
      retune_pulse_r <= 1'b0;
      ana_r <= '0;
      sample_r <= '0;
      sample_vld_r <= 1'b0;
    end else begin
      retune_d_r <= retune_bit;
      retune_pulse_r <= retune_nxt;
      ana_r <= ana_nxt;
      sample_r <= sample_nxt;
      sample_vld_r <= sample_vld_i;
    end
  end

  assign rdata_o = rdata_r;
  assign ana_ctrl_o = ana_r;
  assign osc_retune_pulse_o = retune_pulse_r;
  assign sample_o = sample_r;
  assign sample_vld_o = sample_vld_r;
endmodule : atsd_regs

// ===== tb/atsd_properties.sv
// Purpose: Port-level properties of the analog test and short detect register bank
// Assumes: One clock, synchronous active-high reset, write strobe never beside read strobe
// Notes: Only the mono and retune bits are shadowed, to time their effects against writes
module atsd_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [atsd_pkg::ADDR_W-1:0] addr_i,
  input wire logic [atsd_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [atsd_pkg::DATA_W-1:0] rdata_o,
  // Samples and analog controls
  input wire atsd_pkg::atsd_sample_t sample_i,
  input wire atsd_pkg::atsd_sample_t sample_o,
  input wire atsd_pkg::atsd_ana_ctrl_t ana_ctrl_o,
  input wire logic osc_retune_pulse_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import atsd_pkg::*;
  logic [1:0] shadow_r;
  // Write decodes; a clearing write of the retune bit is the pulse cause
  wire wr_one = wr_i && addr_i == TEST_ONE_OFFS;
  wire wr_two = wr_i && addr_i == TEST_TWO_OFFS;
  wire wr_sc = wr_i && addr_i == SHORT_CTRL_OFFS;
  wire tune_fall = wr_two && shadow_r[0] && !wdata_i[RETUNE_BIT];
  // Mono and retune bits as last written
  always_ff @(posedge clk_i) begin
    shadow_r <= sys_rst_i ? 2'h0 : (wr_two ? wdata_i[MONO_BIT:RETUNE_BIT] : shadow_r);
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_UNMAPPED_ZERO: assert property ($past(rd_i) && $past(addr_i) > 16'h003c |-> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  AST_MONO_COPY: assert property (!$past(sys_rst_i) |-> sample_o == $past({sample_i.left,
    shadow_r[1] ? sample_i.left : sample_i.right})) else $error("sample path wrong");
  AST_RETUNE_PULSE: assert property (osc_retune_pulse_o == $past(tune_fall, 2))
    else $error("retune pulse mistimed");
  AST_SUPPLY_SEL: assert property (wr_two ##1 !wr_two |=> ##1 ana_ctrl_o.lineout_supply_select == $past(wdata_i[14], 3))
    else $error("supply select wrong");
  AST_SPARE_OUT: assert property (wr_two ##1 !wr_two |=> ##1 ana_ctrl_o.spare == $past(wdata_i[13], 3))
    else $error("spare bit wrong");
  AST_DOUBLE_GATED: assert property (ana_ctrl_o.out_conv_double_current |-> ana_ctrl_o.out_conv_class_a_force)
    else $error("double current outside class A");
  AST_TRIP_RIGHT: assert property (wr_sc ##1 !wr_sc |=> ##1 ana_ctrl_o.right_short_trip_level == $past(wdata_i[14:12], 3))
    else $error("right trip level wrong");
  AST_TRIP_LEFT: assert property (wr_sc ##1 !wr_sc |=> ##1 ana_ctrl_o.left_short_trip_level == $past(wdata_i[10:8], 3))
    else $error("left trip level wrong");
  AST_TEST_PATHS: assert property (wr_one ##1 !wr_one |=> ##1 ana_ctrl_o.test_paths_en == $past(wdata_i[0], 3))
    else $error("test path enable wrong");
endmodule : atsd_properties

bind atsd_regs atsd_properties u_props (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .sample_i, .sample_o, .ana_ctrl_o, .osc_retune_pulse_o);

// ===== tb/tb.sv
// Purpose: Register-level self-checking bench for the analog test register bank
// Assumes: Strobes driven right after rising edges, read data checked in the following cycle
// Notes: Retune pulse timing is checked here and by the bound properties
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import atsd_pkg::*;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, sample_vld_i = 1'b0;
  logic [15:0] addr_i = 16'h0000, wdata_i = 16'h0000, rdata_o;
  atsd_sample_t sample_i = '0, sample_o;
  atsd_ana_ctrl_t ana_ctrl_o;
  logic sample_vld_o, osc_retune_pulse_o;
  logic [3:0] b;
  logic [31:0] e;
  int error_cnt = 0, cmp_count = 0;
  atsd_regs dut (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sample_i, .sample_vld_i,
    .sample_o, .sample_vld_o, .ana_ctrl_o, .osc_retune_pulse_o);
  // Free-running 40 MHz clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One-cycle write; returns at the edge that takes it
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask : rd
  // Controls show one edge after the write edge; checked after the second
  task ana(input logic [31:0] exp);
    repeat (2) @(posedge clk_i);
    #1 chk(ana_ctrl_o, exp);
  endtask : ana
  task final_report();
    $display("Compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  // Hang guard, well beyond the hundred-odd cycles of the sequence
  initial begin
    #20000;
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(TEST_ONE_OFFS, 16'h0000);
    rd(TEST_TWO_OFFS, 16'h0000);
    rd(SHORT_CTRL_OFFS, 16'h0000);
    chk(ana_ctrl_o, 32'h0000_0000);
    wr(16'h003e, 16'hffff);
    rd(16'h003e, 16'h0000);
    wr(TEST_ONE_OFFS, 16'hffff);
    rd(TEST_ONE_OFFS, 16'h0001);
    wr(TEST_TWO_OFFS, 16'hffff);
    rd(TEST_TWO_OFFS, 16'h7fff);
    chk(ana_ctrl_o, 32'h007f_fe00);
    // Each control bit alone; double current must stay off without class A
    for (b = 0; b < 15; b++) begin
      wr(TEST_TWO_OFFS, 16'h0001 << b);
      e = (b == 6 || b == 11 || b == 12) ? 32'h0 : 32'h1 << (b > 12 ? b + 7 : b + 9);
      ana(e | 32'h0040_0000);
    end
    wr(TEST_TWO_OFFS, 16'h0050);
    ana(32'h0040_a000);
    // Retune pulse: one cycle, one edge after the clearing write is stored
    wr(TEST_TWO_OFFS, 16'h0800);
    wr(TEST_TWO_OFFS, 16'h0000);
    @(posedge clk_i);
    #1 chk(osc_retune_pulse_o, 1'b1);
    @(posedge clk_i);
    #1 chk(osc_retune_pulse_o, 1'b0);
    // Every trip code, reserved bits set as well
    for (b = 0; b < 8; b++) begin
      wr(SHORT_CTRL_OFFS, 16'h8888 | (16'h1111 * b));
      rd(SHORT_CTRL_OFFS, 16'h1111 * b);
      chk(ana_ctrl_o[8:0], {3{b[2:0]}});
    end
    wr(TEST_TWO_OFFS, 16'h1000);
    @(posedge clk_i);
    sample_i <= 32'h1234_abcd;
    sample_vld_i <= 1'b1;
    @(posedge clk_i);
    #1 chk(sample_o, 32'h1234_1234);
    chk(sample_vld_o, 1'b1);
    wr(TEST_TWO_OFFS, 16'h4000);
    @(posedge clk_i);
    #1 chk(sample_o, 32'h1234_abcd);
    // Reset in mid-run clears the supply select again
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(TEST_TWO_OFFS, 16'h0000);
    final_report();
  end
endmodule : tb
